// file: rtl/tx_sync.sv
// Transmit system sync, backplane sync generator and signaling insertion
//
// Function
// - System sync input acts only while transmit elastic store enabled.
// - Sync pulse sets transmit frame or multiframe boundary as configured.
// - One sync pulse aligns all eight transmit ports together.
// - Sync input driven and sampled synchronous to transmit system clock.
// - Sync pin as output gives 8kHz pulse synchronous to backplane clock.
// - That pulse with backplane clock serves as interleaved bus master timing.
// - Backplane clock may source rx and tx system clocks and sync pin.
// - Signaling insertion samples signaling input into outgoing PCM stream.
// - Elastic store off: sample signaling on tx line clock falling edge.
// - Elastic store on: sample signaling on tx system clock falling edge.
// - Signaling streams support rates up to 16.384MHz in interleaved mode.
// - Port sync pin as output drives frame or multiframe pulse as programmed.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "tx_sync_consts.svh"

module sig_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic  push;
  logic  pop;

  // Pointers wrap at D, which need not be a power of two
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  // Ready drops at D entries; a push and a pop together keep the count
  assign in_ready_o  = (s_q.cnt != CW'(D));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp          = ptr_next(s_q.wp);
    end
    if (pop) begin
      s_d.rp = ptr_next(s_q.rp);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + CW'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // sig_fifo

module tx_sync (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // Clock pins
  input  wire logic        tx_line_clock_i,
  input  wire logic        tx_system_clock_i,
  input  wire logic        backplane_clock_i,
  output logic             rx_system_clock_o,
  output logic             tx_system_clock_o,
  // System sync pin
  input  wire logic        tx_system_sync_pin_i,
  output logic             tx_system_sync_pin_o,
  output logic             tx_system_sync_pin_oe_n_o,
  // Per-port sync pins
  input  wire logic [7:0]  tx_port_sync_pin_i,
  output logic [7:0]       tx_port_sync_pin_o,
  output logic [7:0]       tx_port_sync_pin_oe_n_o,
  // Signaling and PCM stream
  input  wire logic        tx_signaling_input_i,
  input  wire logic        tx_pcm_i,
  output logic             tx_pcm_o
);
  tx_sync_pkg::state_s s_q;
  tx_sync_pkg::state_s s_d;

  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;
  logic        req;

  // Edge detect on a synchronised pin: [1] is current, [2] is previous
  function automatic logic rise3(input logic [2:0] s);
    rise3 = s[1] & ~s[2];
  endfunction

  function automatic logic fall3(input logic [2:0] s);
    fall3 = ~s[1] & s[2];
  endfunction

  // Frame pulse, or multiframe pulse when only frame zero counts
  function automatic logic port_mark(input logic [7:0] cnt_bit, input logic [3:0] cnt_frame,
                                     input logic mf);
    port_mark = (cnt_bit == 8'h00) & (~mf | (cnt_frame == 4'h0));
  endfunction

  assign req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign fifo_pop = req & ~wb_we_i & (wb_adr_i == `ADR_SIG_DATA);

  sig_fifo #(
    .W (`SIG_W),
    .D (`SIG_FIFO_DEPTH)
  ) u_sig_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (s_q.pend_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (s_q.pend_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  always_comb begin
    logic       es_en;
    logic       bp_route;
    logic       sys_src_rise;
    logic       sys_src_fall;
    logic       line_fall;
    logic       step;
    logic       sync_pulse;
    logic       port_any;
    logic       port_pulse;
    logic       align;
    logic       mf_align;
    logic       sig_ins;
    logic       sync_out_en;
    logic       port_out_en;
    logic       bp_wrap;
    logic       byte_done;
    logic       ovf_set;
    logic       ovf_clr;
    logic [2:0] sys_src;

    // Control decode
    es_en        = s_q.ctrl[`CTRL_ES_EN];
    bp_route     = s_q.ctrl[`CTRL_BP_ROUTE];
    sig_ins      = s_q.ctrl[`CTRL_SIG_INS];
    sync_out_en  = s_q.ctrl[`CTRL_SYNC_OUT];
    port_out_en  = s_q.ctrl[`CTRL_PORT_OUT];
    sys_src      = bp_route ? s_q.bp_clk : s_q.sys_clk;
    sys_src_rise = rise3(sys_src);
    sys_src_fall = fall3(sys_src);
    line_fall    = fall3(s_q.line_clk);
    bp_wrap      = (s_q.bp_cnt == `BP_DIV_LAST);

    // Frame timing steps on the falling edge of the active transmit clock
    step         = es_en ? sys_src_fall : line_fall;
    byte_done    = step & sig_ins
                   & (s_q.sig_nbits == `SIG_BYTE_LAST);
    ovf_set      = byte_done & s_q.pend_valid
                   & ~fifo_in_ready;
    ovf_clr      = req & wb_we_i & (wb_adr_i == `ADR_STATUS)
                   & wb_sel_i[2] & wb_dat_i[`STAT_OVF_BIT];
    // Per-cycle defaults
    sync_pulse   = 1'b0;
    port_any     = 1'b0;
    port_pulse   = 1'b0;
    align        = 1'b0;
    mf_align     = 1'b0;

    s_d          = s_q;

    // Pin synchronisers, two flops before any logic
    // Clock pins are sampled, so each must stay below a sixth of clk
    s_d.line_clk = {s_q.line_clk[1:0], tx_line_clock_i};
    s_d.sys_clk  = {s_q.sys_clk[1:0], tx_system_clock_i};
    s_d.bp_clk   = {s_q.bp_clk[1:0], backplane_clock_i};
    s_d.sync_in  = {s_q.sync_in[0], tx_system_sync_pin_i};
    s_d.sig_in   = {s_q.sig_in[0], tx_signaling_input_i};
    s_d.pcm_in   = {s_q.pcm_in[0], tx_pcm_i};
    s_d.port_in  = {s_q.port_in[0], tx_port_sync_pin_i};

    // Sync input taken on the system clock rising edge
    // Only a rising sync edge counts, and none while the pin drives
    if (sys_src_rise) begin
      s_d.sync_prev = s_q.sync_in[1];
      sync_pulse    = s_q.sync_in[1] & ~s_q.sync_prev & es_en & ~sync_out_en;
    end

    // Port sync pins as inputs align the line-timed frame
    s_d.port_prev = s_q.port_in[1];
    port_any      = |(s_q.port_in[1] & ~s_q.port_prev);
    port_pulse    = port_any & ~es_en & ~port_out_en;

    align    = sync_pulse | port_pulse;
    mf_align = align & s_q.ctrl[`CTRL_SYNC_MF];

    // Alignment wins over a step in the same cycle
    if (align) begin
      s_d.bit_cnt = '0;
      if (mf_align) begin
        s_d.frame_cnt = '0;
      end
    end else if (step) begin
      s_d.bit_cnt = s_q.bit_cnt + 8'h01;
      if (s_q.bit_cnt == `FRAME_LAST_BIT) begin
        s_d.frame_cnt = s_q.frame_cnt + 4'h1;
      end
    end

    // Signaling sampling and insertion into PCM
    if (step) begin
      s_d.pcm_o = s_q.pcm_in[1];
      if (sig_ins) begin
        if (s_q.bit_cnt[2:0] == `SIG_SLOT_BIT) begin
          s_d.pcm_o = s_q.sig_in[1];
        end
        s_d.sig_byte  = {s_q.sig_byte[6:0], s_q.sig_in[1]};
        s_d.sig_nbits = s_q.sig_nbits + 3'h1;
      end
    end
    if (s_q.pend_valid && fifo_in_ready) begin
      s_d.pend_valid = 1'b0;
    end
    // A byte finished while the last one still waits for room overwrites it
    if (byte_done) begin
      s_d.pend_byte  = {s_q.sig_byte[6:0], s_q.sig_in[1]};
      s_d.pend_valid = 1'b1;
    end
    // Overflow sticks; its set wins over a same-cycle clear
    if (ovf_set) begin
      s_d.ovf = 1'b1;
    end

    // Per-port sync outputs, all eight on one shared timing
    for (int p = 0; p < 8; p++) begin
      s_d.port_oe_n[p] = ~port_out_en;
      s_d.port_o[p]    = port_mark(s_q.bit_cnt, s_q.frame_cnt, s_q.ctrl[`CTRL_PORT_MF]);
    end

    // 8kHz sync generator on the backplane clock
    if (rise3(s_q.bp_clk)) begin
      s_d.bp_cnt     = bp_wrap ? 11'h000 : s_q.bp_cnt + 11'h001;
      s_d.sync_pin_o = bp_wrap & sync_out_en;
    end
    s_d.sync_pin_oe_n = ~sync_out_en;

    // Backplane clock routed out as system clocks
    // Both stay low while routing is off
    s_d.rx_clk_o = bp_route & s_q.bp_clk[1];
    s_d.tx_clk_o = bp_route & s_q.bp_clk[1];

    // Wishbone slave, one wait state
    // Ack is registered, so a strobe held under ack is not taken twice
    s_d.ack = req;
    s_d.dat = '0;
    if (req) begin
      case (wb_adr_i)
        `ADR_CTRL: begin
          s_d.dat[7:0] = s_q.ctrl;
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.ctrl = wb_dat_i[7:0];
          end
        end
        `ADR_STATUS: begin
          s_d.dat[7:0]                       = s_q.bit_cnt;
          s_d.dat[`STAT_FRAME_LSB +: 4]      = s_q.frame_cnt;
          s_d.dat[`STAT_EMPTY_BIT]           = ~fifo_out_valid;
          s_d.dat[`STAT_OVF_BIT]             = s_q.ovf;
          if (ovf_clr) begin
            s_d.ovf = ovf_set;
          end
        end
        `ADR_SIG_DATA: begin
          s_d.dat[7:0]            = fifo_out_valid ? fifo_out_data : 8'h00;
          s_d.dat[`SIG_VALID_BIT] = fifo_out_valid;
        end
        default: begin
          s_d.dat = '0;
        end
      endcase
    end
  end

  // Reset releases the system and port sync pins and clears the counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.ctrl      <= `CTRL_RESET;
      s_q.sync_pin_oe_n <= 1'b1;
      s_q.port_oe_n <= 8'hFF;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the registered state
  assign wb_ack_o                  = s_q.ack;
  assign wb_dat_o                  = s_q.dat;
  assign rx_system_clock_o         = s_q.rx_clk_o;
  assign tx_system_clock_o         = s_q.tx_clk_o;
  assign tx_system_sync_pin_o      = s_q.sync_pin_o;
  assign tx_system_sync_pin_oe_n_o = s_q.sync_pin_oe_n;
  assign tx_port_sync_pin_o        = s_q.port_o;
  assign tx_port_sync_pin_oe_n_o   = s_q.port_oe_n;
  assign tx_pcm_o                  = s_q.pcm_o;
endmodule // tx_sync

// file: rtl/tx_sync_consts.svh
// Offsets, field positions, reset values and timing counts of the transmit sync block
`ifndef TX_SYNC_CONSTS_SVH
`define TX_SYNC_CONSTS_SVH

`define ADR_CTRL        8'h00
`define ADR_STATUS      8'h04
`define ADR_SIG_DATA    8'h08

`define CTRL_ES_EN      0
`define CTRL_SYNC_OUT   1
`define CTRL_SYNC_MF    2
`define CTRL_SIG_INS    3
`define CTRL_PORT_OUT   4
`define CTRL_PORT_MF    5
`define CTRL_BP_ROUTE   6
`define CTRL_RESET      8'h00

`define STAT_FRAME_LSB  8
`define STAT_EMPTY_BIT  12
`define STAT_OVF_BIT    16
`define SIG_VALID_BIT   8

`define FRAME_LAST_BIT  8'hFF
`define MF_LAST_FRAME   4'hF
`define SIG_SLOT_BIT    3'h7
`define SIG_BYTE_LAST   3'h7

`define SYNC_RATE_HZ    8000
`define BP_CLOCK_HZ     16384000
`define BP_DIV_LAST     (11'(`BP_CLOCK_HZ / `SYNC_RATE_HZ - 1))

`define SIG_W           8
`define SIG_FIFO_DEPTH  4

`endif

// file: rtl/tx_sync_pkg.sv
// Types shared by the transmit sync block
package tx_sync_pkg;

  typedef struct packed {
    logic [2:0]      line_clk;
    logic [2:0]      sys_clk;
    logic [2:0]      bp_clk;
    logic [1:0]      sync_in;
    logic [1:0]      sig_in;
    logic [1:0]      pcm_in;
    logic [1:0][7:0] port_in;
    logic [7:0]      port_prev;
    logic            sync_prev;
    logic [7:0]      ctrl;
    logic [7:0]      bit_cnt;
    logic [3:0]      frame_cnt;
    logic [10:0]     bp_cnt;
    logic            sync_pin_o;
    logic            sync_pin_oe_n;
    logic [7:0]      port_o;
    logic [7:0]      port_oe_n;
    logic            pcm_o;
    logic            rx_clk_o;
    logic            tx_clk_o;
    logic [7:0]      sig_byte;
    logic [2:0]      sig_nbits;
    logic            pend_valid;
    logic [7:0]      pend_byte;
    logic            ovf;
    logic            ack;
    logic [31:0]     dat;
  } state_s;

endpackage

// file: tb/tx_sync_sva.sv
// Port-level assertions for the transmit sync block
`timescale 1ns/1ps
module tx_sync_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Pins
  input wire logic        rx_system_clock_o,
  input wire logic        tx_system_clock_o,
  input wire logic        tx_system_sync_pin_o,
  input wire logic        tx_system_sync_pin_oe_n_o,
  input wire logic [7:0]  tx_port_sync_pin_o,
  input wire logic [7:0]  tx_port_sync_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_ports_alike: assert property (tx_port_sync_pin_o inside {8'h00, 8'hFF})
    else $error("port pulses differ");
  a_port_oe_alike: assert property (tx_port_sync_pin_oe_n_o inside {8'h00, 8'hFF})
    else $error("port enables differ");
  a_routes_alike: assert property (rx_system_clock_o == tx_system_clock_o)
    else $error("routed clocks differ");
  a_sync_width: assert property ($rose(tx_system_sync_pin_o) |=> tx_system_sync_pin_o [*2])
    else $error("sync pulse too short");
  a_oe_reset: assert property ($fell(rst_i) |-> tx_system_sync_pin_oe_n_o && &tx_port_sync_pin_oe_n_o)
    else $error("pin driven right after reset");
endmodule // tx_sync_sva
bind tx_sync tx_sync_sva tx_sync_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .rx_system_clock_o, .tx_system_clock_o, .tx_system_sync_pin_o,
  .tx_system_sync_pin_oe_n_o, .tx_port_sync_pin_o, .tx_port_sync_pin_oe_n_o);

// file: tb/sys_side_model.sv
// Far-side system logic: transmit clocks and system sync driver
`timescale 1ns/1ps
module sys_side_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic [1:0] run_i,
  input  wire logic       req_i,
  // Pins toward the device
  output logic            line_clk_o,
  output logic            sys_clk_o,
  output logic            bp_clk_o,
  output logic            sync_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       line, sys, bp, sync;
  } model_s;
  model_s q, d;
  always_comb begin
    d = q;
    d.cnt = q.cnt + 4'h1;
    d.bp = d.cnt[3];
    if (run_i[0]) begin
      d.line = d.cnt[3];
    end
    if (run_i[1]) begin
      d.sys = d.cnt[3];
    end
    // Sync moves only as the system clock falls, low unless asked
    if (run_i[1] && q.cnt == 4'hF) begin
      d.sync = req_i & ~q.sync;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign line_clk_o = q.line;
  assign sys_clk_o = q.sys;
  assign bp_clk_o = q.bp;
  assign sync_o = q.sync;
endmodule // sys_side_model

// file: tb/tx_sync_test.sv
// Self-checking bench for the transmit sync block
`timescale 1ns/1ps
`include "tx_sync_consts.svh"
module tx_sync_test;
  logic        clk_i = 0, rst_i = 1, req = 0, hit;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [1:0]  run = 2'h0;
  logic        tx_line_clock_i, tx_system_clock_i, backplane_clock_i, msync;
  logic        rx_system_clock_o, tx_system_clock_o, tx_pcm_o;
  logic        tx_system_sync_pin_o, tx_system_sync_pin_oe_n_o;
  logic        tx_signaling_input_i = 1, tx_pcm_i = 0;
  logic [7:0]  tx_port_sync_pin_o, tx_port_sync_pin_oe_n_o;
  int          fails = 0, n_checks = 0;
  wire         tx_system_sync_pin_i = tx_system_sync_pin_oe_n_o ? msync : tx_system_sync_pin_o;
  wire [7:0]   tx_port_sync_pin_i = tx_port_sync_pin_o & ~tx_port_sync_pin_oe_n_o;
  tx_sync tx_sync_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .wb_dat_o, .tx_line_clock_i, .tx_system_clock_i, .backplane_clock_i,
    .rx_system_clock_o, .tx_system_clock_o, .tx_system_sync_pin_i, .tx_system_sync_pin_o,
    .tx_system_sync_pin_oe_n_o, .tx_port_sync_pin_i, .tx_port_sync_pin_o,
    .tx_port_sync_pin_oe_n_o, .tx_signaling_input_i, .tx_pcm_i, .tx_pcm_o);
  sys_side_model sys_side_model_i (.clk_i, .rst_i, .run_i(run), .req_i(req),
    .line_clk_o(tx_line_clock_i), .sys_clk_o(tx_system_clock_i),
    .bp_clk_o(backplane_clock_i), .sync_o(msync));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rdat = wb_dat_o;
    chk("ack", 1, wb_ack_o);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  function automatic logic pick(int w);
    case (w)
      0: return tx_port_sync_pin_o[0];
      1: return tx_pcm_o;
      2: return tx_system_sync_pin_o;
      default: return rx_system_clock_o;
    endcase
  endfunction
  task automatic watch(input int w, input int n);
    hit = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (pick(w) === 1'b1) hit = 1;
    end
  endtask
  task automatic pulse(input logic [7:0] c);
    logic h;
    wb(1, `ADR_CTRL, {24'h0, c}, 4'hF);
    req <= 1;
    watch(0, 24);
    h = hit;
    req <= 0;
    watch(0, 60);
    hit = hit | h;
  endtask
  task automatic t_reset();
    chk("oe_n", 32'h1FF, {tx_system_sync_pin_oe_n_o, tx_port_sync_pin_oe_n_o});
    wb(0, `ADR_CTRL, 0, 4'hF);
    chk("ctrl", 0, rdat);
    wb(0, 8'h0C, 0, 4'hF);
    chk("unmapped", 0, rdat);
  endtask
  task automatic t_align();
    run <= 2'b10;
    // Step the frame off zero before any port pulse is watched
    wb(1, `ADR_CTRL, 32'h01, 4'hF);
    repeat (40) @(posedge clk_i);
    pulse(8'h11);
    chk("frame_pulse", 1, hit);
    pulse(8'h35);
    chk("mf_pulse", 1, hit);
    pulse(8'h10);
    chk("ignored_sync", 0, hit);
  endtask
  task automatic t_sig(input logic es);
    int n;
    n = 0;
    run <= es ? 2'b10 : 2'b01;
    wb(1, `ADR_CTRL, es ? 32'h09 : 32'h08, 4'hF);
    watch(1, 300);
    chk("pcm_insert", 1, hit);
    repeat (1500) @(posedge clk_i);
    run <= 2'b00;
    repeat (40) @(posedge clk_i);
    wb(0, `ADR_STATUS, 0, 4'hF);
    chk("ovf", 1, rdat[`STAT_OVF_BIT]);
    wb(1, `ADR_STATUS, 32'h10000, 4'h4);
    wb(0, `ADR_STATUS, 0, 4'hF);
    chk("ovf_clear", 0, rdat[`STAT_OVF_BIT]);
    for (int i = 0; i < 8; i++) begin
      wb(0, `ADR_SIG_DATA, 0, 4'hF);
      if (rdat[`SIG_VALID_BIT] === 1'b1) n++;
      if (rdat[`SIG_VALID_BIT] === 1'b1) chk("sig_byte", 32'h1FF, rdat);
    end
    chk("drained", 1, n >= 4);
    wb(0, `ADR_STATUS, 0, 4'hF);
    chk("empty", 1, rdat[`STAT_EMPTY_BIT]);
  endtask
  task automatic t_bp();
    wb(1, `ADR_CTRL, 32'h42, 4'hF);
    repeat (3) @(posedge clk_i);
    chk("sync_oe_n", 0, tx_system_sync_pin_oe_n_o);
    watch(3, 60);
    chk("routed_clock", 1, hit);
    watch(2, 34000);
    chk("sync_out", 1, hit);
    wb(1, `ADR_CTRL, 0, 4'hF);
    repeat (3) @(posedge clk_i);
    watch(3, 60);
    chk("unrouted_clock", 0, hit);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_reset();
    t_align();
    t_sig(1);
    t_sig(0);
    t_bp();
    tally_and_finish();
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule // tx_sync_test
